// File: rtl/drive_cmd_pkg.sv
// Constants, field positions and mode codes of the drive command register.
// Assumes one 50 MHz clock domain and a synchronous active-high reset.
package drive_cmd_pkg;

  localparam int CMD_W = 16;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Bits 0-14 belong to the rack processor, bit 15 to the operating system
  localparam logic [15:0] RACK_WRITE_MASK = 16'h7fff;

  localparam int B_CURRENT_LOOP_RUN = 0;
  localparam int B_ARMATURE_IDENT_TEST = 1;
  localparam int B_ARMATURE_ALPHA_TEST_ENABLE = 2;
  localparam int B_ARMATURE_ALPHA_REVERSE_SELECT = 3;
  localparam int B_FIELD_LOOP_RUN = 4;
  localparam int B_FIELD_IDENT_TEST = 5;
  localparam int B_FIELD_ALPHA_TEST_ENABLE = 6;
  localparam int B_FIELD_ALPHA_REVERSE_SELECT = 7;
  localparam int B_FAULT_CLEAR_PULSE = 8;
  localparam int B_WARNING_CLEAR_PULSE = 9;
  localparam int B_DISABLE_AUTO_FIELD_WEAKENING = 11;
  localparam int B_CONTROLLER_TASK_RUNNING = 15;

  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Operating mode reported to the power interface processor
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_CURRENT_RUN = 3'b001,
    MODE_ARMATURE_IDENT = 3'b010,
    MODE_ARMATURE_ALPHA = 3'b011,
    MODE_FIELD_IDENT = 3'b100,
    MODE_FIELD_ALPHA = 3'b101
  } mode_t;

  // Armature run/stop sequence
  typedef enum logic [1:0] {
    RUN_OFF = 2'b00,
    RUN_ON = 2'b01,
    RUN_STOPPING = 2'b10
  } run_state_t;

endpackage

// File: rtl/scan_edge_if.sv
// Carrier between the command register and its scan edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface scan_edge_if #(parameter int W = 16);
  logic scan;
  logic [W-1:0] cmd;
  logic [W-1:0] cur;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport detector (input scan, input cmd, output cur, output rise, output fall);
  modport owner (output scan, output cmd, input cur, input rise, input fall);
endinterface

// File: rtl/scan_edge_detect.sv
// Scan snapshot of the command word and per-bit transition pulses.
// Assumes scan is a one-cycle strobe marking the end of a controller scan.
`timescale 1ns/1ns
module scan_edge_detect #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic srst,
  scan_edge_if.detector e
);

  logic [W-1:0] cur_r, cur_nxt;
  logic [W-1:0] rise_r, rise_nxt;
  logic [W-1:0] fall_r, fall_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Comparing this scan with the last one, so a held bit acts only once
  always_comb begin
    cur_nxt = cur_r;
    rise_nxt = '0;
    fall_nxt = '0;
    if (e.scan) begin
      cur_nxt = e.cmd;
      rise_nxt = e.cmd & ~cur_r;
      fall_nxt = ~e.cmd & cur_r;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r <= '0;
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      cur_r <= cur_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign e.cur = cur_r;
  assign e.rise = rise_r;
  assign e.fall = fall_r;

endmodule

// File: rtl/drive_command_control.sv
// Drive command register with its scan-based command decoding, the run
// sequence, the fault/warning/interlock latches and the field reference choice.
// Stop All clears bits 0-14 of both the stored word and the scan snapshot.
// Assumes all inputs are synchronous to clk and scan_end pulses once per scan.
`timescale 1ns/1ns
module drive_command_control #(
  parameter int W = 16,
  parameter int FAULT_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic wr_from_rack,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] rd_data,
  input wire logic task_running,
  input wire logic stop_all,
  input wire logic scan_end,
  input wire logic contactor_fitted,
  input wire logic discontinuous_conduction,
  input wire logic speed_feedback_present,
  input wire logic [FAULT_W-1:0] fault_cond,
  input wire logic [FAULT_W-1:0] warning_cond,
  input wire logic [FAULT_W-1:0] interlock_cond,
  input wire logic [W-1:0] cemf,
  input wire logic [W-1:0] voltage_limit,
  input wire logic [W-1:0] field_ref_reg,
  input wire logic [W-1:0] field_ref_calc,
  input wire logic [W-1:0] armature_firing_angle,
  input wire logic [W-1:0] field_firing_angle,
  output drive_cmd_pkg::mode_t mode,
  output logic contactor_close,
  output logic current_loop_enable,
  output logic current_zero_cmd,
  output logic armature_ident_active,
  output logic armature_alpha_active,
  output logic armature_bridge_reverse,
  output logic [W-1:0] armature_test_angle,
  output logic field_loop_enable,
  output logic field_ident_active,
  output logic field_alpha_active,
  output logic field_bridge_reverse,
  output logic [W-1:0] field_test_angle,
  output logic field_weakening_active,
  output logic [W-1:0] field_ref_out,
  output logic [FAULT_W-1:0] fault_reg,
  output logic [FAULT_W-1:0] warning_reg,
  output logic [FAULT_W-1:0] interlock_reg
);

  // Latch new events; a clear never drops an event arriving the same cycle
  function automatic logic [FAULT_W-1:0] latch(input logic [FAULT_W-1:0] held,
                                               input logic [FAULT_W-1:0] ev,
                                               input logic clr);
    latch = (clr ? '0 : held) | ev;
  endfunction

  // Unsigned compare; both field references share one scale
  function automatic logic [W-1:0] min_of(input logic [W-1:0] a, input logic [W-1:0] b);
    min_of = (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Command word storage
  logic [W-1:0] cmd_r, cmd_nxt;

  // Only rack writes reach bits 0-14; bit 15 follows the task status
  always_comb begin
    cmd_nxt = cmd_r;
    if (wr_en && wr_from_rack) begin
      cmd_nxt = (cmd_r & ~drive_cmd_pkg::RACK_WRITE_MASK)
              | (wr_data & drive_cmd_pkg::RACK_WRITE_MASK);
    end
    // Status bit is never taken from a write
    cmd_nxt[drive_cmd_pkg::B_CONTROLLER_TASK_RUNNING] = task_running;
    if (stop_all) begin
      cmd_nxt = drive_cmd_pkg::CMD_RESET;
      cmd_nxt[drive_cmd_pkg::B_CONTROLLER_TASK_RUNNING] = task_running;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_r <= drive_cmd_pkg::CMD_RESET;
      rd_data <= drive_cmd_pkg::CMD_RESET;
    end else begin
      cmd_r <= cmd_nxt;
      rd_data <= cmd_nxt; // Reads show stored command bits, not action status
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan snapshot and transitions
  scan_edge_if #(.W(W)) sx ();

  // Stop All also snapshots the emptied word, so a command bit set again
  // afterwards is seen as a fresh transition and can restart the drive
  assign sx.scan = scan_end || stop_all;
  assign sx.cmd = stop_all ? (cmd_r & ~drive_cmd_pkg::RACK_WRITE_MASK) : cmd_r;

  scan_edge_detect #(.W(W)) u_edges (
    .clk(clk),
    .srst(srst),
    .e(sx.detector)
  );

  // Snapshot as the decoders see it
  logic [W-1:0] c;
  assign c = sx.cur;

  // Marks the cycle after a Stop All, whose falling edges are not clear pulses
  logic stop_q_r, stop_q_nxt;

  always_comb begin
    stop_q_nxt = stop_all;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stop_q_r <= 1'b0;
    end else begin
      stop_q_r <= stop_q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Armature run sequence
  drive_cmd_pkg::run_state_t run_r, run_nxt;

  // Stopping commands zero current and keeps the contactor until conduction ends
  always_comb begin
    run_nxt = run_r;
    case (run_r)
      drive_cmd_pkg::RUN_OFF: begin
        if (sx.rise[drive_cmd_pkg::B_CURRENT_LOOP_RUN]) begin
          run_nxt = drive_cmd_pkg::RUN_ON;
        end
      end
      drive_cmd_pkg::RUN_ON: begin
        if (sx.fall[drive_cmd_pkg::B_CURRENT_LOOP_RUN]) begin
          run_nxt = drive_cmd_pkg::RUN_STOPPING;
        end
      end
      drive_cmd_pkg::RUN_STOPPING: begin
        if (sx.rise[drive_cmd_pkg::B_CURRENT_LOOP_RUN]) begin
          run_nxt = drive_cmd_pkg::RUN_ON;
        end else if (discontinuous_conduction) begin
          run_nxt = drive_cmd_pkg::RUN_OFF;
        end
      end
      default: run_nxt = drive_cmd_pkg::RUN_OFF;
    endcase
    // Stop All skips the zero-current phase
    if (stop_all) begin
      run_nxt = drive_cmd_pkg::RUN_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run_r <= drive_cmd_pkg::RUN_OFF;
    end else begin
      run_r <= run_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Armature bridge choice, frozen when the alpha test starts
  logic a_rev_hold_r, a_rev_hold_nxt;

  // A change of bit 3 in mid-test must not swap bridges under a firing angle
  always_comb begin
    a_rev_hold_nxt = a_rev_hold_r;
    if (sx.rise[drive_cmd_pkg::B_ARMATURE_ALPHA_TEST_ENABLE]) begin
      a_rev_hold_nxt = c[drive_cmd_pkg::B_ARMATURE_ALPHA_REVERSE_SELECT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      a_rev_hold_r <= 1'b0;
    end else begin
      a_rev_hold_r <= a_rev_hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded outputs, all registered
  drive_cmd_pkg::mode_t mode_nxt;
  logic contactor_nxt, cl_en_nxt, zero_nxt;
  logic a_id_nxt, a_al_nxt, a_rev_nxt, f_run_nxt, f_id_nxt, f_al_nxt, f_rev_nxt;
  logic [W-1:0] a_ang_nxt, f_ang_nxt;
  logic run_on, fw_nxt;
  logic [W-1:0] fref_nxt;

  // Tests follow the scan snapshot, so a bit is honoured only while held
  always_comb begin
    run_on = (run_r == drive_cmd_pkg::RUN_ON);
    contactor_nxt = contactor_fitted && (run_r != drive_cmd_pkg::RUN_OFF);
    // Minor loop stays off while bit 15 (task running) of the scan snapshot is clear
    cl_en_nxt = run_on && c[drive_cmd_pkg::B_CONTROLLER_TASK_RUNNING];
    zero_nxt = (run_r == drive_cmd_pkg::RUN_STOPPING);
    a_id_nxt = c[drive_cmd_pkg::B_ARMATURE_IDENT_TEST];
    a_al_nxt = c[drive_cmd_pkg::B_ARMATURE_ALPHA_TEST_ENABLE];
    // Bridge is the one chosen from bit 3 when the test started
    a_rev_nxt = a_al_nxt && a_rev_hold_nxt;
    a_ang_nxt = a_al_nxt ? armature_firing_angle : '0;
    f_run_nxt = c[drive_cmd_pkg::B_FIELD_LOOP_RUN];
    f_id_nxt = c[drive_cmd_pkg::B_FIELD_IDENT_TEST];
    f_al_nxt = c[drive_cmd_pkg::B_FIELD_ALPHA_TEST_ENABLE];
    f_rev_nxt = f_al_nxt && c[drive_cmd_pkg::B_FIELD_ALPHA_REVERSE_SELECT];
    f_ang_nxt = f_al_nxt ? field_firing_angle : '0;
    // Priority when several modes are asked for at once: run first
    if (run_on) begin
      mode_nxt = drive_cmd_pkg::MODE_CURRENT_RUN;
    end else if (a_id_nxt) begin
      mode_nxt = drive_cmd_pkg::MODE_ARMATURE_IDENT;
    end else if (a_al_nxt) begin
      mode_nxt = drive_cmd_pkg::MODE_ARMATURE_ALPHA;
    end else if (f_id_nxt) begin
      mode_nxt = drive_cmd_pkg::MODE_FIELD_IDENT;
    end else if (f_al_nxt) begin
      mode_nxt = drive_cmd_pkg::MODE_FIELD_ALPHA;
    end else begin
      mode_nxt = drive_cmd_pkg::MODE_IDLE;
    end
    // Without speed feedback the disable bit is ignored and weakening is off
    fw_nxt = speed_feedback_present
           && !c[drive_cmd_pkg::B_DISABLE_AUTO_FIELD_WEAKENING];
    if (fw_nxt && (cemf > voltage_limit)) begin
      fref_nxt = min_of(field_ref_reg, field_ref_calc);
    end else begin
      fref_nxt = field_ref_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault, warning and interlock latches
  logic [FAULT_W-1:0] fault_nxt, warning_nxt, interlock_nxt;
  logic fault_clr, warn_clr;

  // Clears act on the falling edge of a set-then-clear pulse, once
  always_comb begin
    // A Stop All empties the word but is not a set-then-clear pulse
    fault_clr = sx.fall[drive_cmd_pkg::B_FAULT_CLEAR_PULSE] && !stop_q_r;
    warn_clr = sx.fall[drive_cmd_pkg::B_WARNING_CLEAR_PULSE] && !stop_q_r;
    fault_nxt = latch(fault_reg, fault_cond, fault_clr);
    warning_nxt = latch(warning_reg, warning_cond, warn_clr);
    interlock_nxt = latch(interlock_reg, interlock_cond, warn_clr);
  end

  // Latch registers, all three groups in one register process
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_reg <= drive_cmd_pkg::STATUS_RESET;
      warning_reg <= drive_cmd_pkg::STATUS_RESET;
      interlock_reg <= drive_cmd_pkg::STATUS_RESET;
    end else begin
      fault_reg <= fault_nxt;
      warning_reg <= warning_nxt;
      interlock_reg <= interlock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers of the decoded commands
  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= drive_cmd_pkg::MODE_IDLE;
      contactor_close <= 1'b0;
      current_loop_enable <= 1'b0;
      current_zero_cmd <= 1'b0;
      armature_ident_active <= 1'b0;
      armature_alpha_active <= 1'b0;
      armature_bridge_reverse <= 1'b0;
      armature_test_angle <= '0;
      field_loop_enable <= 1'b0;
      field_ident_active <= 1'b0;
      field_alpha_active <= 1'b0;
      field_bridge_reverse <= 1'b0;
      field_test_angle <= '0;
      field_weakening_active <= 1'b0;
      field_ref_out <= '0;
    end else begin
      mode <= mode_nxt;
      contactor_close <= contactor_nxt;
      current_loop_enable <= cl_en_nxt;
      current_zero_cmd <= zero_nxt;
      armature_ident_active <= a_id_nxt;
      armature_alpha_active <= a_al_nxt;
      armature_bridge_reverse <= a_rev_nxt;
      armature_test_angle <= a_ang_nxt;
      field_loop_enable <= f_run_nxt;
      field_ident_active <= f_id_nxt;
      field_alpha_active <= f_al_nxt;
      field_bridge_reverse <= f_rev_nxt;
      field_test_angle <= f_ang_nxt;
      field_weakening_active <= fw_nxt;
      field_ref_out <= fref_nxt;
    end
  end

endmodule

// File: testbench/drive_command_control_props.sv
// Checker for the drive command register top module.
// Sees only top-level ports; bound in by the statement at the foot.
`timescale 1ns/1ns
module drive_command_control_props #(
  parameter int W = 16,
  parameter int FAULT_W = 16
) (
  input logic clk,
  input logic srst,
  input logic wr_en,
  input logic wr_from_rack,
  input logic [W-1:0] wr_data,
  input logic [W-1:0] rd_data,
  input logic task_running,
  input logic stop_all,
  input logic scan_end,
  input logic speed_feedback_present,
  input logic [FAULT_W-1:0] fault_cond,
  input logic contactor_close,
  input logic field_weakening_active,
  input logic [FAULT_W-1:0] fault_reg,
  input logic [FAULT_W-1:0] warning_reg,
  input logic [FAULT_W-1:0] interlock_reg,
  input drive_cmd_pkg::mode_t mode
);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Register write path and its refusals
  AST_WR_RACK: assert property (
    wr_en && wr_from_rack && !stop_all |=> rd_data[W-2:0] == $past(wr_data[W-2:0]))
    else $error("rack write not taken");
  AST_WR_HOLD: assert property (
    !(wr_en && wr_from_rack) && !stop_all |=> $stable(rd_data[W-2:0]))
    else $error("command word changed without a rack write");
  AST_STATUS: assert property (
    1'b1 |=> rd_data[W-1] == $past(task_running))
    else $error("status bit does not follow task running");
  AST_STOP: assert property (
    stop_all |=> (rd_data & drive_cmd_pkg::RACK_WRITE_MASK) == 16'h0000 ##1 !contactor_close)
    else $error("stop all did not discard commands");

  // Event latches: set on any event, clear only two cycles after a falling scan
  AST_FAULT_SET: assert property (
    |fault_cond |=> (fault_reg & $past(fault_cond)) == $past(fault_cond))
    else $error("fault event not latched");
  AST_FAULT_EDGE: assert property (
    |($past(fault_reg) & ~fault_reg) |->
      $past(scan_end, 2) && !$past(rd_data[drive_cmd_pkg::B_FAULT_CLEAR_PULSE], 2))
    else $error("fault latch cleared without a reset pulse");
  AST_WARN_EDGE: assert property (
    |(($past(warning_reg) & ~warning_reg) | ($past(interlock_reg) & ~interlock_reg)) |->
      $past(scan_end, 2) && !$past(rd_data[drive_cmd_pkg::B_WARNING_CLEAR_PULSE], 2))
    else $error("warning latch cleared without a reset pulse");
  AST_NO_FB: assert property (
    !speed_feedback_present [*3] |-> !field_weakening_active)
    else $error("weakening active without speed feedback");

  // Main scenarios reached
  cover property (mode == drive_cmd_pkg::MODE_CURRENT_RUN);
  cover property (|fault_reg ##1 !(|fault_reg));
  cover property (stop_all ##1 !contactor_close);
endmodule

bind drive_command_control drive_command_control_props #(.W(W), .FAULT_W(FAULT_W)) u_props (
  .clk, .srst, .wr_en, .wr_from_rack, .wr_data, .rd_data, .task_running, .stop_all,
  .scan_end, .speed_feedback_present, .fault_cond, .contactor_close,
  .field_weakening_active, .fault_reg, .warning_reg, .interlock_reg, .mode);

// File: testbench/tb.sv
// Self-checking bench for the drive command register.
// Assumes the checker is bound in; drives all inputs 1 ns after clk rises.
`timescale 1ns/1ns
module tb;
  logic clk, srst, wr_en, wr_from_rack, task_running, stop_all, scan_end;
  logic contactor_fitted, discontinuous_conduction, speed_feedback_present;
  logic [15:0] wr_data, rd_data, cemf, voltage_limit, field_ref_reg, field_ref_calc, d, f;
  logic [15:0] armature_firing_angle, field_firing_angle, armature_test_angle;
  logic [15:0] field_test_angle, field_ref_out, fault_cond, warning_cond, interlock_cond;
  logic [15:0] fault_reg, warning_reg, interlock_reg;
  logic contactor_close, current_loop_enable, current_zero_cmd, armature_ident_active;
  logic armature_alpha_active, armature_bridge_reverse, field_loop_enable;
  logic field_ident_active, field_alpha_active, field_bridge_reverse, field_weakening_active;
  drive_cmd_pkg::mode_t mode;
  logic [20:0] q[$];
  int n_errors = 0;
  int cmp_count = 0;
  localparam int RD = 0, MD = 1, AANG = 2, FANG = 3, FREF = 4, FLT = 5, WRN = 6, ILK = 7;
  localparam int CC = 8, LE = 9, ZC = 10, AI = 11, AA = 12, AR = 13, FL = 14, FI = 15;
  localparam int FA = 16, FR = 17, FW = 18;
  logic [15:0] mcode [5] = '{16'h0002, 16'h0004, 16'h0020, 16'h0040, 16'h0000};
  drive_cmd_pkg::mode_t mexp [5] = '{drive_cmd_pkg::MODE_ARMATURE_IDENT,
    drive_cmd_pkg::MODE_ARMATURE_ALPHA, drive_cmd_pkg::MODE_FIELD_IDENT,
    drive_cmd_pkg::MODE_FIELD_ALPHA, drive_cmd_pkg::MODE_IDLE};
  logic [15:0] obsv [8];
  logic [10:0] flags;

  drive_command_control u_drive_command_control (.clk, .srst, .wr_en, .wr_from_rack,
    .wr_data, .rd_data, .task_running, .stop_all, .scan_end, .contactor_fitted,
    .discontinuous_conduction, .speed_feedback_present, .fault_cond, .warning_cond,
    .interlock_cond, .cemf, .voltage_limit, .field_ref_reg, .field_ref_calc,
    .armature_firing_angle, .field_firing_angle, .mode, .contactor_close,
    .current_loop_enable, .current_zero_cmd, .armature_ident_active, .armature_alpha_active,
    .armature_bridge_reverse, .armature_test_angle, .field_loop_enable, .field_ident_active,
    .field_alpha_active, .field_bridge_reverse, .field_test_angle, .field_weakening_active,
    .field_ref_out, .fault_reg, .warning_reg, .interlock_reg);

  ////////////////////////////////////////////////////////////
  // Observed results, indexed by the selector kept in each note
  assign obsv = '{rd_data, {13'h0000, mode}, armature_test_angle, field_test_angle,
    field_ref_out, fault_reg, warning_reg, interlock_reg};
  assign flags = {field_weakening_active, field_bridge_reverse, field_alpha_active,
    field_ident_active, field_loop_enable, armature_bridge_reverse, armature_alpha_active,
    armature_ident_active, current_zero_cmd, current_loop_enable, contactor_close};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic note(input int s, input logic [15:0] e);
    q.push_back({s[4:0], e});
  endtask

  task automatic cmp(input logic [20:0] n);
    logic [15:0] a;
    a = (n[20:16] < 5'h08) ? obsv[n[18:16]] : {15'h0000, flags[n[20:16] - 5'h08]};
    cmp_count++;
    if (a !== n[15:0]) begin
      n_errors++;
      $display("Error at %0t: sel %0d expected %h got %h", $time, n[20:16], n[15:0], a);
    end
  endtask

  task automatic wr(input logic [15:0] v, input logic rack = 1'b1);
    wr_en = 1'b1;
    wr_data = v;
    wr_from_rack = rack;
    tick();
    wr_en = 1'b0;
    tick(); // Idle cycle, so a following write never re-raises the strobe at once
  endtask

  // Write, then one scan, then wait until the run sequence has settled too
  task automatic cmd(input logic [15:0] v);
    wr(v);
    scan_end = 1'b1;
    tick();
    scan_end = 1'b0;
    tick(4);
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Notes are settled by the falling edge, so every pending one is compared there
  always @(negedge clk) begin
    while (q.size() > 0)
      cmp(q.pop_front());
  end

  // Cuts a hang short; the sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(57464));
    {srst, task_running, contactor_fitted, speed_feedback_present} = 4'hf;
    {wr_en, wr_from_rack, stop_all, scan_end, discontinuous_conduction} = 5'h00;
    {wr_data, fault_cond, warning_cond, interlock_cond} = 64'h0;
    {cemf, voltage_limit, field_ref_reg, field_ref_calc} = 64'h0200_0100_4000_3000;
    armature_firing_angle = 16'($urandom);
    field_firing_angle = 16'($urandom);
    tick(2);
    srst = 1'b0;
    repeat (3) begin
      d = 16'($urandom) & 16'h7fff;
      wr(d);
      note(RD, {1'b1, d[14:0]});
    end
    wr(~d, 1'b0);
    note(RD, {1'b1, d[14:0]});
    task_running = 1'b0;
    tick();
    note(RD, {1'b0, d[14:0]});
    task_running = 1'b1;
    // Run and stop, with and without a contactor fitted
    for (int i = 1; i >= 0; i--) begin
      contactor_fitted = i[0];
      cmd(16'h0000);
      note(MD, 16'h0000);
      cmd(16'h0001);
      note(MD, 16'h0001);
      note(CC, {15'h0000, i[0]});
      note(LE, 16'h0001);
      cmd(16'h0000);
      note(ZC, 16'h0001);
      note(CC, {15'h0000, i[0]});
      discontinuous_conduction = 1'b1;
      tick(3);
      note(CC, 16'h0000);
      note(ZC, 16'h0000);
      discontinuous_conduction = 1'b0;
    end
    foreach (mcode[k]) begin
      cmd(mcode[k]);
      note(MD, {13'h0000, mexp[k]});
      note(AI, {15'h0000, mcode[k][1]});
      note(FI, {15'h0000, mcode[k][5]});
    end
    cmd(16'h0008);
    cmd(16'h000c);
    note(AA, 16'h0001);
    note(AR, 16'h0001);
    note(AANG, armature_firing_angle);
    cmd(16'h00d0);
    note(FL, 16'h0001);
    note(FA, 16'h0001);
    note(FR, 16'h0001);
    note(FANG, field_firing_angle);
    // Latch events; a held reset bit must not clear, a released one clears once
    f = 16'($urandom) | 16'h0001;
    {fault_cond, warning_cond, interlock_cond} = {f, ~f, f};
    tick();
    {fault_cond, warning_cond, interlock_cond} = 48'h0;
    cmd(16'h0300);
    cmd(16'h0300);
    note(FLT, f);
    note(WRN, ~f);
    note(ILK, f);
    fault_cond = f;
    cmd(16'h0000);
    note(FLT, f);
    note(WRN, 16'h0000);
    note(ILK, 16'h0000);
    fault_cond = 16'h0000;
    cmd(16'h0100);
    cmd(16'h0000);
    note(FLT, 16'h0000);
    // Field reference choice
    note(FW, 16'h0001);
    note(FREF, field_ref_calc);
    cemf = 16'h0080;
    tick(2);
    note(FREF, field_ref_reg);
    cemf = 16'h0200;
    cmd(16'h0800);
    note(FW, 16'h0000);
    note(FREF, field_ref_reg);
    cmd(16'h0000);
    speed_feedback_present = 1'b0;
    tick(3);
    note(FW, 16'h0000);
    speed_feedback_present = 1'b1;
    contactor_fitted = 1'b1;
    cmd(16'h0011);
    note(CC, 16'h0001);
    task_running = 1'b0;
    cmd(16'h0011);
    note(LE, 16'h0000);
    note(CC, 16'h0001);
    task_running = 1'b1;
    stop_all = 1'b1;
    tick();
    stop_all = 1'b0;
    note(RD, 16'h8000);
    tick();
    note(CC, 16'h0000);
    note(FL, 16'h0000);
    tick();
    tally_and_finish();
  end
endmodule
